// file: bench/accel_control_checker.sv
`timescale 1ns/1ns
module accel_control_checker #(
  parameter int PULSE_CYCLES = 10
) (
  // Clocks and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       link_clk,
  // Register link
  input wire logic       reg_req,
  input wire logic       reg_ready,
  input wire logic       reg_rvalid,
  input wire logic [7:0] reg_rdata,
  // Event pin and mode
  input wire logic       event_pin_one,
  input wire logic       measuring
);
  logic [15:0] high_run_reg;
  logic        pending_reg;

  // Length of the current high stretch on the pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) high_run_reg <= 16'h0000;
    else if (event_pin_one) high_run_reg <= high_run_reg + 16'h0001;
    else high_run_reg <= 16'h0000;
  end

  // One access owed an answer; a take in the answer cycle keeps it owed
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) pending_reg <= 1'b0;
    else if (reg_req && reg_ready) pending_reg <= 1'b1;
    else if (reg_rvalid) pending_reg <= 1'b0;
  end

  sequence s_take;
    reg_req && reg_ready;
  endsequence
  sequence s_answer;
    ##[3:5] reg_rvalid;
  endsequence

  take_answer_a: assert property (@(posedge link_clk) disable iff (!rst_n) s_take |-> s_answer)
    else $error("access not answered in 3 to 5 link cycles");
  busy_after_take_a: assert property (@(posedge link_clk) disable iff (!rst_n) s_take |=> !reg_ready)
    else $error("link still ready after a take");
  ready_at_answer_a: assert property (@(posedge link_clk) disable iff (!rst_n) reg_rvalid |-> reg_ready)
    else $error("link busy while answering");
  answer_once_a: assert property (@(posedge link_clk) disable iff (!rst_n) reg_rvalid |=> !reg_rvalid)
    else $error("answer longer than one cycle");
  answer_owed_a: assert property (@(posedge link_clk) disable iff (!rst_n) reg_rvalid |-> pending_reg)
    else $error("answer without a request");
  rdata_hold_a: assert property (@(posedge link_clk) disable iff (!rst_n) $changed(reg_rdata) |-> reg_rvalid)
    else $error("read data moved between answers");
  pulse_width_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(event_pin_one) && measuring |-> high_run_reg == 16'(PULSE_CYCLES))
    else $error("event pulse of wrong width");
  pulse_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    measuring |-> high_run_reg <= 16'(PULSE_CYCLES))
    else $error("event pin held like a level");
endmodule : accel_control_checker

bind accel_control accel_control_checker #(.PULSE_CYCLES(PULSE_CYCLES)) chk_inst (.ref_clk, .rst_n, .link_clk,
  .reg_req, .reg_ready, .reg_rvalid, .reg_rdata, .event_pin_one, .measuring);

// file: bench/host_model.sv
`timescale 1ns/1ns
module host_model (
  // Link clock and reset
  input  wire logic       link_clk,
  input  wire logic       rst_n,
  // Requests
  output logic            reg_req,
  output logic            reg_write,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  // Answers
  input  wire logic       reg_ready,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_req   = 1'b0;
    reg_write = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // Released lines show the inverse, so a stale copy is never mistaken for a request
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] r, output logic ok);
    int   n;
    logic t;
    @(posedge link_clk);
    #1;
    reg_req   = 1'b1;
    reg_write = wr;
    reg_addr  = a;
    reg_wdata = d;
    n = 0;
    do begin
      t = reg_ready;
      @(posedge link_clk);
      #1;
      n++;
    end while (!t && n < 20);
    reg_req   = 1'b0;
    reg_write = ~wr;
    reg_addr  = ~a;
    reg_wdata = ~d;
    n = 0;
    do begin
      @(posedge link_clk);
      #1;
      n++;
    end while (!reg_rvalid && n < 10);
    r  = reg_rdata;
    ok = reg_rvalid;
  endtask : access
endmodule : host_model

// file: bench/tb.sv
`timescale 1ns/1ns
module tb;
  import accel_pkg::*;
  localparam int PERIOD = 16;
  logic        ref_clk;
  logic        link_clk;
  logic        rst_n;
  logic        reg_req;
  logic        reg_write;
  logic        reg_ready;
  logic        reg_rvalid;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [15:0] axis_x;
  logic [15:0] axis_y;
  logic [15:0] axis_z;
  logic        event_pin_one;
  logic        measuring;
  int          mismatches;
  int          compares;
  int          n;
  logic [7:0]  modes [4] = '{8'h00, 8'h40, 8'h60, 8'hc0};
  logic [7:0]  axes [6]  = '{8'h23, 8'h81, 8'h45, 8'h7f, 8'h67, 8'hfe};
  logic [7:0]  wide [6]  = '{8'h34, 8'h12, 8'h45, 8'h7f, 8'h67, 8'hfe};

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;
  initial link_clk = 1'b0;
  always #40 link_clk = ~link_clk;

  accel_control #(.SAMPLE_PERIOD(PERIOD), .PULSE_CYCLES(10)) uut (.ref_clk, .rst_n, .link_clk, .reg_req,
    .reg_write, .reg_addr, .reg_wdata, .reg_ready, .reg_rdata, .reg_rvalid, .axis_x, .axis_y, .axis_z,
    .event_pin_one, .measuring);

  host_model host (.link_clk, .rst_n, .reg_req, .reg_write, .reg_addr, .reg_wdata, .reg_ready, .reg_rdata,
    .reg_rvalid);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       ok;
    host.access(1'b1, a, d, r, ok);
    check({7'h00, ok}, 8'h01);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] r;
    logic       ok;
    host.access(1'b0, a, 8'h00, r, ok);
    if (ok !== 1'b1) r = 8'hxx;
    check(r & m, e);
  endtask : rd

  // Waits for the pin; mid-fill the X sample changes so old bytes differ from new
  task automatic wait_pin(input int limit);
    n = 0;
    while (event_pin_one !== 1'b1 && n < limit) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n == 5000) axis_x = 16'h1234;
    end
  endtask : wait_pin

  initial begin
    #150000;
    mismatches++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    axis_x = 16'h8123;
    axis_y = 16'h7f45;
    axis_z = 16'hfe67;
    mismatches = 0;
    compares = 0;
    repeat (2) @(posedge link_clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(ADDR_SAMPLE_RATE, 8'hff, 8'h02);
    wr(ADDR_SAMPLE_RATE, 8'h02);
    rd(ADDR_SAMPLE_RATE, 8'hff, 8'h02);
    rd(8'h30, 8'hff, 8'h00);
    wr(ADDR_INT_PIN, 8'h38);
    check({7'h00, event_pin_one}, 8'h00);
    foreach (modes[i]) begin
      wr(ADDR_MAIN_CONTROL, modes[i]);
      check({7'h00, measuring}, {7'h00, modes[i][7]});
      rd(ADDR_MAIN_CONTROL, 8'hff, modes[i]);
    end
    repeat (2 * PERIOD) @(posedge ref_clk);
    foreach (axes[i]) rd(ADDR_X_LOW + 8'(i), 8'hff, axes[i]);
    wr(ADDR_MAIN_CONTROL, 8'h00);
    wr(ADDR_INT_ROUTING, 8'h10);
    wr(ADDR_MAIN_CONTROL, 8'he0);
    wait_pin(4 * PERIOD);
    check({7'h00, event_pin_one}, 8'h01);
    rd(ADDR_STATUS, 8'h10, 8'h10);
    rd(ADDR_INT_SOURCE_TWO, 8'h10, 8'h10);
    wr(ADDR_MAIN_CONTROL, 8'h00);
    repeat (20) @(posedge ref_clk);
    wr(ADDR_INT_ROUTING, 8'h40);
    wr(ADDR_BUF_CONTROL2, 8'ha0);
    wr(ADDR_MAIN_CONTROL, 8'h80);
    wait_pin(12000);
    check({7'h00, event_pin_one}, 8'h01);
    check({7'h00, n > 680 * PERIOD - 200}, 8'h01);
    wr(ADDR_MAIN_CONTROL, 8'h00);
    rd(ADDR_STATUS, 8'h10, 8'h10);
    rd(ADDR_INT_SOURCE_TWO, 8'h40, 8'h40);
    rd(ADDR_X_LOW, 8'hff, 8'h00);
    rd(ADDR_BUF_CONTROL2, 8'hff, 8'ha0);
    for (int i = 0; i < 6; i++) rd(ADDR_BUF_READ, 8'hff, axes[2 * (i % 3) + 1]);
    // Wide samples: buffer restarted empty, low byte ahead of high byte
    wr(ADDR_BUF_CONTROL2, 8'h00);
    wr(ADDR_BUF_CONTROL2, 8'he0);
    wr(ADDR_MAIN_CONTROL, 8'hc0);
    wr(ADDR_MAIN_CONTROL, 8'h00);
    foreach (wide[i]) rd(ADDR_BUF_READ, 8'hff, wide[i]);
    final_report();
  end
endmodule : tb

// file: src/accel_control.sv
`timescale 1ns/1ns
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW + 1)'(DEPTH)) && !flush;
  assign out_valid = (count_reg != '0) && !flush;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : sample_fifo

module accel_control
  import accel_pkg::*;
#(
  parameter int SAMPLE_PERIOD = SAMPLE_PERIOD_CYCLES,
  parameter int PULSE_CYCLES  = PULSE_MIN_CYCLES
) (
  // Core clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Register link
  input  wire logic        link_clk,
  input  wire logic        reg_req,
  input  wire logic        reg_write,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic             reg_ready,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  // Acceleration front end
  input  wire logic [15:0] axis_x,
  input  wire logic [15:0] axis_y,
  input  wire logic [15:0] axis_z,
  // Event pin and mode
  output logic             event_pin_one,
  output logic             measuring
);
  // Link domain
  logic       busy_reg;
  logic       req_tgl_reg;
  logic       write_hold_reg;
  logic [7:0] addr_hold_reg;
  logic [7:0] wdata_hold_reg;
  logic       ack_s1_reg;
  logic       ack_s2_reg;
  logic       ack_seen_reg;
  // Core domain
  logic       req_s1_reg;
  logic       req_s2_reg;
  logic       req_seen_reg;
  logic       ack_tgl_reg;
  logic [7:0] rdata_core_reg;
  logic [7:0] main_control_reg;
  logic [7:0] sample_rate_reg;
  logic [7:0] int_pin_reg;
  logic [7:0] int_routing_reg;
  logic [7:0] buf_control2_reg;
  logic [15:0] x_reg;
  logic [15:0] y_reg;
  logic [15:0] z_reg;
  logic       new_sample_flag_reg;
  logic       fifo_full_flag_reg;
  logic [31:0] rate_count_reg;
  logic       tick;
  logic       req_pulse;
  logic       wr_hit;
  logic       rd_hit;
  seq_state_t seq_state_reg;
  logic [7:0] seq_bytes_reg [0:5];
  logic [2:0] seq_idx_reg;
  logic [2:0] seq_last_reg;
  logic       st_in_ready;
  logic       st_out_valid;
  logic       st_out_ready;
  logic [7:0] st_out_data;
  logic [7:0] buf_mem [0:BUF_BYTES-1];
  logic [10:0] buf_wr_reg;
  logic [10:0] buf_rd_reg;
  logic [11:0] buf_count_reg;
  logic [11:0] buf_cap;
  logic       buf_push;
  logic       buf_pop;
  logic       buf_en;
  logic       full_event;
  logic       new_event;
  logic       pin_event;
  logic [31:0] pulse_count_reg;
  logic       pin_level;

  function automatic logic [31:0] rate_period(input logic [3:0] code);
    logic [31:0] base;
    base = 32'(SAMPLE_PERIOD);
    if (code >= RATE_CODE_50HZ) begin
      rate_period = base >> (code - RATE_CODE_50HZ);
    end else begin
      rate_period = base << (RATE_CODE_50HZ - code);
    end
  endfunction : rate_period

  function automatic logic [11:0] buffer_capacity(input logic res16);
    buffer_capacity = res16 ? FULL_LEVEL_16BIT : FULL_LEVEL_8BIT;
  endfunction : buffer_capacity

  // Request copies are held stable while busy, so the core may read them directly
  assign reg_ready = !busy_reg;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg       <= 1'b0;
      req_tgl_reg    <= 1'b0;
      write_hold_reg <= 1'b0;
      addr_hold_reg  <= 8'h00;
      wdata_hold_reg <= 8'h00;
    end else if (reg_req && !busy_reg) begin
      busy_reg       <= 1'b1;
      req_tgl_reg    <= !req_tgl_reg;
      write_hold_reg <= reg_write;
      addr_hold_reg  <= reg_addr;
      wdata_hold_reg <= reg_wdata;
    end else if (ack_s2_reg != ack_seen_reg) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1_reg   <= 1'b0;
      ack_s2_reg   <= 1'b0;
      ack_seen_reg <= 1'b0;
      reg_rdata    <= 8'h00;
      reg_rvalid   <= 1'b0;
    end else begin
      ack_s1_reg   <= ack_tgl_reg;
      ack_s2_reg   <= ack_s1_reg;
      ack_seen_reg <= ack_s2_reg;
      reg_rvalid   <= (ack_s2_reg != ack_seen_reg);
      if (ack_s2_reg != ack_seen_reg) begin
        reg_rdata <= rdata_core_reg;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1_reg   <= 1'b0;
      req_s2_reg   <= 1'b0;
      req_seen_reg <= 1'b0;
      ack_tgl_reg  <= 1'b0;
    end else begin
      req_s1_reg   <= req_tgl_reg;
      req_s2_reg   <= req_s1_reg;
      req_seen_reg <= req_s2_reg;
      if (req_pulse) begin
        ack_tgl_reg <= !ack_tgl_reg;
      end
    end
  end

  assign req_pulse = req_s2_reg != req_seen_reg;
  assign wr_hit    = req_pulse && write_hold_reg;
  assign rd_hit    = req_pulse && !write_hold_reg;

  // Control registers; the host keeps them still while running
  // Standby configuration
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_control_reg <= MAIN_CONTROL_RST;
      sample_rate_reg  <= SAMPLE_RATE_RST;
      int_pin_reg      <= INT_PIN_RST;
      int_routing_reg  <= INT_ROUTING_RST;
      buf_control2_reg <= BUF_CONTROL2_RST;
    end else if (wr_hit) begin
      if (addr_hold_reg == ADDR_MAIN_CONTROL) begin
        main_control_reg <= wdata_hold_reg;
      end else if (addr_hold_reg == ADDR_SAMPLE_RATE) begin
        sample_rate_reg <= wdata_hold_reg;
      end else if (addr_hold_reg == ADDR_INT_PIN) begin
        int_pin_reg <= wdata_hold_reg;
      end else if (addr_hold_reg == ADDR_INT_ROUTING) begin
        int_routing_reg <= wdata_hold_reg;
      end else if (addr_hold_reg == ADDR_BUF_CONTROL2) begin
        buf_control2_reg <= wdata_hold_reg;
      end
    end
  end

  // Read data; unmapped addresses read as zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_core_reg <= 8'h00;
    end else if (rd_hit) begin
      if (addr_hold_reg == ADDR_X_LOW) begin
        rdata_core_reg <= x_reg[7:0];
      end else if (addr_hold_reg == ADDR_X_HIGH) begin
        rdata_core_reg <= x_reg[15:8];
      end else if (addr_hold_reg == ADDR_Y_LOW) begin
        rdata_core_reg <= y_reg[7:0];
      end else if (addr_hold_reg == ADDR_Y_HIGH) begin
        rdata_core_reg <= y_reg[15:8];
      end else if (addr_hold_reg == ADDR_Z_LOW) begin
        rdata_core_reg <= z_reg[7:0];
      end else if (addr_hold_reg == ADDR_Z_HIGH) begin
        rdata_core_reg <= z_reg[15:8];
      end else if (addr_hold_reg == ADDR_STATUS) begin
        rdata_core_reg <= 8'h00;
        rdata_core_reg[STATUS_INT_BIT] <= new_sample_flag_reg || fifo_full_flag_reg;
      end else if (addr_hold_reg == ADDR_INT_SOURCE_TWO) begin
        rdata_core_reg <= 8'h00;
        rdata_core_reg[SRC2_NEW_DATA_BIT] <= new_sample_flag_reg;
        rdata_core_reg[SRC2_FULL_BIT]     <= fifo_full_flag_reg;
      end else if (addr_hold_reg == ADDR_MAIN_CONTROL) begin
        rdata_core_reg <= main_control_reg;
      end else if (addr_hold_reg == ADDR_SAMPLE_RATE) begin
        rdata_core_reg <= sample_rate_reg;
      end else if (addr_hold_reg == ADDR_INT_PIN) begin
        rdata_core_reg <= int_pin_reg;
      end else if (addr_hold_reg == ADDR_INT_ROUTING) begin
        rdata_core_reg <= int_routing_reg;
      end else if (addr_hold_reg == ADDR_BUF_CONTROL2) begin
        rdata_core_reg <= buf_control2_reg;
      end else if (addr_hold_reg == ADDR_BUF_READ) begin
        rdata_core_reg <= (buf_count_reg != '0) ? buf_mem[buf_rd_reg] : 8'h00;
      end else begin
        rdata_core_reg <= 8'h00;
      end
    end
  end

  assign measuring = main_control_reg[RUN_SELECT_BIT];
  assign tick      = measuring && (rate_count_reg == '0);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_count_reg <= '0;
    end else if (!measuring || tick) begin
      rate_count_reg <= rate_period(sample_rate_reg[3:0]) - 32'h1;
    end else begin
      rate_count_reg <= rate_count_reg - 32'h1;
    end
  end

  // Low power keeps only the high byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      x_reg <= 16'h0000;
      y_reg <= 16'h0000;
      z_reg <= 16'h0000;
    end else if (tick) begin
      x_reg <= main_control_reg[HIGH_RES_BIT] ? axis_x : {axis_x[15:8], 8'h00};
      y_reg <= main_control_reg[HIGH_RES_BIT] ? axis_y : {axis_y[15:8], 8'h00};
      z_reg <= main_control_reg[HIGH_RES_BIT] ? axis_z : {axis_z[15:8], 8'h00};
    end
  end

  // A sample arriving while the sequencer still pushes the previous one is dropped
  // High bytes X, Y, Z; in 16-bit mode low then high byte of X, Y, Z
  assign buf_en = buf_control2_reg[BUF_ENABLE_BIT];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_state_reg <= SEQ_IDLE;
      seq_idx_reg   <= 3'h0;
      seq_last_reg  <= 3'h0;
      for (int i = 0; i < 6; i++) begin
        seq_bytes_reg[i] <= 8'h00;
      end
    end else begin
      case (seq_state_reg)
        SEQ_IDLE: begin
          if (tick && buf_en) begin
            seq_state_reg <= SEQ_PUSH;
            seq_idx_reg   <= 3'h0;
            if (buf_control2_reg[BUF_RES16_BIT]) begin
              seq_last_reg     <= 3'h5;
              seq_bytes_reg[0] <= axis_x[7:0];
              seq_bytes_reg[1] <= axis_x[15:8];
              seq_bytes_reg[2] <= axis_y[7:0];
              seq_bytes_reg[3] <= axis_y[15:8];
              seq_bytes_reg[4] <= axis_z[7:0];
              seq_bytes_reg[5] <= axis_z[15:8];
            end else begin
              seq_last_reg     <= 3'h2;
              seq_bytes_reg[0] <= axis_x[15:8];
              seq_bytes_reg[1] <= axis_y[15:8];
              seq_bytes_reg[2] <= axis_z[15:8];
            end
          end
        end
        SEQ_PUSH: begin
          if (!buf_en) begin
            seq_state_reg <= SEQ_IDLE;
          end else if (st_in_ready) begin
            seq_idx_reg <= seq_idx_reg + 3'h1;
            if (seq_idx_reg == seq_last_reg) begin
              seq_state_reg <= SEQ_IDLE;
            end
          end
        end
        default: begin
          seq_state_reg <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Staging queue decouples byte pushes from the sample buffer
  sample_fifo #(
    .WIDTH (8),
    .DEPTH (STAGE_DEPTH)
  ) u_stage (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .flush     (!buf_en),
    .in_valid  (seq_state_reg == SEQ_PUSH),
    .in_ready  (st_in_ready),
    .in_data   (seq_bytes_reg[seq_idx_reg]),
    .out_valid (st_out_valid),
    .out_ready (st_out_ready),
    .out_data  (st_out_data)
  );

  // Stop filling at the full level
  assign buf_cap      = buffer_capacity(buf_control2_reg[BUF_RES16_BIT]);
  assign st_out_ready = buf_en && (buf_count_reg < buf_cap);
  assign buf_push     = st_out_valid && st_out_ready;
  assign buf_pop      = rd_hit && (addr_hold_reg == ADDR_BUF_READ) && (buf_count_reg != '0);
  assign full_event   = buf_push && !buf_pop && (buf_count_reg == buf_cap - 12'h1);
  assign new_event    = tick && main_control_reg[NEW_DATA_EN_BIT];

  always_ff @(posedge ref_clk) begin
    if (buf_push) begin
      buf_mem[buf_wr_reg] <= st_out_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_wr_reg    <= '0;
      buf_rd_reg    <= '0;
      buf_count_reg <= '0;
    end else if (!buf_en) begin
      buf_wr_reg    <= '0;
      buf_rd_reg    <= '0;
      buf_count_reg <= '0;
    end else begin
      if (buf_push) begin
        buf_wr_reg <= buf_wr_reg + 11'h1;
      end
      if (buf_pop) begin
        buf_rd_reg <= buf_rd_reg + 11'h1;
      end
      if (buf_push && !buf_pop) begin
        buf_count_reg <= buf_count_reg + 12'h1;
      end else if (buf_pop && !buf_push) begin
        buf_count_reg <= buf_count_reg - 12'h1;
      end
    end
  end

  // Flags clear on a source read; a new event in that cycle wins
  // New data flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      new_sample_flag_reg <= 1'b0;
    end else if (new_event) begin
      new_sample_flag_reg <= 1'b1;
    end else if (rd_hit && addr_hold_reg == ADDR_INT_SOURCE_TWO) begin
      new_sample_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_full_flag_reg <= 1'b0;
    end else if (full_event && buf_control2_reg[BUF_REPORT_BIT]) begin
      fifo_full_flag_reg <= 1'b1;
    end else if (rd_hit && addr_hold_reg == ADDR_INT_SOURCE_TWO) begin
      fifo_full_flag_reg <= 1'b0;
    end
  end

  assign pin_event = (new_event && int_routing_reg[ROUTE_NEW_DATA_BIT]) ||
                     (full_event && buf_control2_reg[BUF_REPORT_BIT] && int_routing_reg[ROUTE_FULL_BIT]);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_count_reg <= '0;
    end else if (pin_event) begin
      pulse_count_reg <= 32'(PULSE_CYCLES);
    end else if (pulse_count_reg != '0) begin
      pulse_count_reg <= pulse_count_reg - 32'h1;
    end
  end

  // Latched mode holds the level until the source register is read
  assign pin_level = int_pin_reg[PIN_PULSE_BIT] ? (pulse_count_reg != '0) :
                     ((new_sample_flag_reg && int_routing_reg[ROUTE_NEW_DATA_BIT]) ||
                      (fifo_full_flag_reg && int_routing_reg[ROUTE_FULL_BIT]));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_pin_one <= 1'b0;
    end else begin
      event_pin_one <= (int_pin_reg[PIN_ENABLE_BIT] && pin_level) ~^ int_pin_reg[PIN_POLARITY_BIT];
    end
  end
endmodule : accel_control

// file: src/accel_pkg.sv
// Operation
// - Top control bit starts active measurement
// - 0x40: standby, high resolution, 2g range
// - 0x60 also enables new-data event
// - 0x00: standby, low power, 2g range
// - Rate code 0x02 means 50 Hz, reset value
// - 0x38 enables event pin, active high
// - Pin events are short pulses, not latched
// - Routing 0x10 sends new-data to pin
// - Routing 0x40 sends buffer-full to pin
// - Axis values in two's complement byte pairs
// - New data sets status and source bit4
// - 0xA0: buffer on, 8-bit, report, first-in-first-out
// - Buffer read port returns signed samples
// - Buffer full sets status bit4, source bit6
// - 8-bit mode stores high bytes X,Y,Z
// - Oldest buffered byte is read first
// - Full at 2043 bytes, 681 samples in 8-bit mode; 2040 bytes, 340 samples in 16-bit mode
package accel_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_X_LOW          = 8'h06;
  localparam logic [7:0] ADDR_X_HIGH         = 8'h07;
  localparam logic [7:0] ADDR_Y_LOW          = 8'h08;
  localparam logic [7:0] ADDR_Y_HIGH         = 8'h09;
  localparam logic [7:0] ADDR_Z_LOW          = 8'h0a;
  localparam logic [7:0] ADDR_Z_HIGH         = 8'h0b;
  localparam logic [7:0] ADDR_STATUS         = 8'h15;
  localparam logic [7:0] ADDR_INT_SOURCE_TWO = 8'h17;
  localparam logic [7:0] ADDR_MAIN_CONTROL   = 8'h18;
  localparam logic [7:0] ADDR_SAMPLE_RATE    = 8'h1b;
  localparam logic [7:0] ADDR_INT_PIN        = 8'h1c;
  localparam logic [7:0] ADDR_INT_ROUTING    = 8'h1f;
  localparam logic [7:0] ADDR_BUF_CONTROL2   = 8'h3b;
  localparam logic [7:0] ADDR_BUF_READ       = 8'h3f;
  // Field positions
  localparam int RUN_SELECT_BIT     = 7;
  localparam int HIGH_RES_BIT       = 6;
  localparam int NEW_DATA_EN_BIT    = 5;
  localparam int PIN_ENABLE_BIT     = 5;
  localparam int PIN_POLARITY_BIT   = 4;
  localparam int PIN_PULSE_BIT      = 3;
  localparam int ROUTE_NEW_DATA_BIT = 4;
  localparam int ROUTE_FULL_BIT     = 6;
  localparam int BUF_ENABLE_BIT     = 7;
  localparam int BUF_RES16_BIT      = 6;
  localparam int BUF_REPORT_BIT     = 5;
  localparam int STATUS_INT_BIT     = 4;
  localparam int SRC2_NEW_DATA_BIT  = 4;
  localparam int SRC2_FULL_BIT      = 6;
  // Reset values
  localparam logic [7:0] MAIN_CONTROL_RST = 8'h00;
  localparam logic [7:0] SAMPLE_RATE_RST  = 8'h02;
  localparam logic [7:0] INT_PIN_RST      = 8'h00;
  localparam logic [7:0] INT_ROUTING_RST  = 8'h00;
  localparam logic [7:0] BUF_CONTROL2_RST = 8'h00;
  localparam logic [3:0] RATE_CODE_50HZ   = 4'h2;
  // Sample buffer
  localparam int          BUF_BYTES        = 2048;
  localparam logic [11:0] FULL_LEVEL_8BIT  = 12'h7fb;
  localparam logic [11:0] FULL_LEVEL_16BIT = 12'h7f8;
  localparam int          STAGE_DEPTH      = 32;
  // Timing
  localparam int CLK_MHZ              = 250;
  localparam int PULSE_MIN_US         = 30;
  localparam int PULSE_MIN_CYCLES     = PULSE_MIN_US * CLK_MHZ;
  localparam int SAMPLE_RATE_HZ       = 50;
  localparam int SAMPLE_PERIOD_CYCLES = CLK_MHZ * 1000000 / SAMPLE_RATE_HZ;
  // Byte sequencer
  typedef enum logic [0:0] {SEQ_IDLE, SEQ_PUSH} seq_state_t;
endpackage : accel_pkg
